// ==== hw/ufc_core.sv ====
// Purpose: serial transmitter and receiver with 64-entry fifos behind wishbone
// Assumes: one clock clk_sys at 200 MHz, rx and cts are asynchronous pins
// Notes:   divisor is an integer count of clk_sys per oversample tick
//
// Summary of operation
// - character length five to eight bits
// - even, odd, stick or no parity
// - one or two stop bits transmitted
// - break generate on tx, detect on rx
// - tx fifo 64x8, rx fifo 64x12
// - programmable bit rate up to 12.5 Mbps, 25 Mbps at 8x
// - rx entry: data, frame, parity, break, overrun
// - full fifo: set overrun, drop character
// - next stored character carries overrun, then clears
// - enabled tx sends back to back until empty
// - busy set as soon as tx non-empty
// - busy clears after last stop bit leaves
// - busy ignores enable, follows pending data
// - three samples per bit, majority wins
// - recheck start at 8th tick, 4th at 8x, reject false
// - data bits sampled every 16th tick, 8th at 8x
// - check parity; low stop means framing error
// - finished character stored with its flags
// - fifo off: bottom entry is holding register; here it is the entry at the pointer, which keeps advancing
// - fifo off: unread character causes overrun
// - fifo off: flags emulate one entry
// - tick is 16x rate, 8x when selected
// - cts enabled: start a character only while cts asserted
// - rts drops at watermark, returns below it
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module ufc_core (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rst,       // synchronous reset, active high
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // write enable
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte lanes
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic      [31:0] wb_dat_o,  // read data
  output logic             wb_ack_o,  // acknowledge
  input  wire logic        rxPin,     // serial in
  input  wire logic        ctsPin_n,  // clear to send, active low
  output logic             txPin,     // serial out
  output logic             rtsPin_n   // request to send, active low
);
  // configuration registers
  logic [7:0]  lineCtl_q;
  logic [3:0]  ctrl_q;
  logic [15:0] div_q;
  logic [5:0]  water_q;
  // fifo storage and pointers
  logic [7:0]  txMem [ufc_pkg::FifoDepth];
  ufc_pkg::ufc_rxent_s rxMem [ufc_pkg::FifoDepth];
  logic [ufc_pkg::PtrW:0] txWr_q, txRd_q, rxWr_q, rxRd_q;
  logic [ufc_pkg::PtrW:0] txCnt, rxCnt;
  logic txEmpty, txFull, rxEmpty, rxFull, fifoOn;
  // bus decode
  logic wbReq, wrData, rdData, wrLane0;
  // oversample tick
  logic [15:0] divCnt_q;
  logic        tick;
  // synchronisers
  logic [1:0]  rxSync_q, ctsSync_q;
  logic        rxIn, ctsOk;
  // transmitter
  ufc_pkg::ufc_tx_e txSt_q;
  logic [11:0] txShf_q;
  logic [3:0]  txBits_q;
  logic [4:0]  txTick_q;
  logic        txPop;
  // receiver
  ufc_pkg::ufc_rx_e rxSt_q;
  logic [4:0]  rxTick_q;
  logic [3:0]  rxBit_q;
  logic [7:0]  rxShf_q;
  logic        rxParAcc_q, parErr_q, overrun_q, rxPush;
  ufc_pkg::ufc_rxent_s rxEnt;
  logic [2:0]  vote_q;
  logic [8:0]  lowBits_q;
  logic [3:0]  dataLen, frameBits;
  logic [4:0]  ovsLast, ovsMid;
  logic        majority;

  assign fifoOn  = lineCtl_q[ufc_pkg::LcFifoEn];
  assign dataLen = 4'd5 + {2'b00, lineCtl_q[ufc_pkg::LcLenLo +: 2]};
  // start + data + parity + one stop, used for break timing
  assign frameBits = dataLen + 4'd2 + {3'b000, lineCtl_q[ufc_pkg::LcParEn]};
  assign ovsLast = ctrl_q[ufc_pkg::CrOvs8] ? 5'd7 : 5'd15;
  assign ovsMid  = ctrl_q[ufc_pkg::CrOvs8] ? 5'd3 : ufc_pkg::StartCheck;
  assign txCnt   = txWr_q - txRd_q;
  assign rxCnt   = rxWr_q - rxRd_q;
  assign txEmpty = (txCnt == '0);
  // with fifos off one entry already counts as full
  assign txFull  = fifoOn ? (txCnt == 7'd64) : !txEmpty;
  assign rxEmpty = (rxCnt == '0);
  assign rxFull  = fifoOn ? (rxCnt == 7'd64) : !rxEmpty;
  assign wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrLane0 = wbReq && wb_we_i && wb_sel_i[0];
  assign wrData  = wrLane0 && (wb_adr_i == ufc_pkg::RegData) && !txFull;
  assign rdData  = wbReq && !wb_we_i && (wb_adr_i == ufc_pkg::RegData) && !rxEmpty;
  assign rxIn    = rxSync_q[1];
  assign ctsOk   = !ctrl_q[ufc_pkg::CrCtsEn] || !ctsSync_q[1];
  assign majority = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2])
                  | (vote_q[0] & vote_q[2]);

  // wishbone slave: one ack per request, single cycle latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        unique case (wb_adr_i)
          ufc_pkg::RegData:    wb_dat_o <= {20'h0, rxMem[rxRd_q[5:0]]};
          ufc_pkg::RegFlag:    wb_dat_o <= {24'h0, txEmpty, rxFull, txFull, rxEmpty,
                                            (txSt_q != ufc_pkg::TxIdle) || !txEmpty,
                                            2'b00, !ctsSync_q[1]};
          ufc_pkg::RegLineCtl: wb_dat_o <= {24'h0, lineCtl_q};
          ufc_pkg::RegCtrl:    wb_dat_o <= {28'h0, ctrl_q};
          ufc_pkg::RegDivisor: wb_dat_o <= {16'h0, div_q};
          ufc_pkg::RegWater:   wb_dat_o <= {26'h0, water_q};
          default:             wb_dat_o <= ufc_pkg::BusUnmapped;
        endcase
      end
    end
  end

  // configuration writes, low lanes only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lineCtl_q <= ufc_pkg::LineCtlReset;
      ctrl_q    <= ufc_pkg::CtrlReset;
      div_q     <= ufc_pkg::DivReset;
      water_q   <= ufc_pkg::WaterReset;
    end else if (wrLane0) begin
      if (wb_adr_i == ufc_pkg::RegLineCtl) lineCtl_q <= wb_dat_i[7:0];
      if (wb_adr_i == ufc_pkg::RegCtrl)    ctrl_q    <= wb_dat_i[3:0];
      if (wb_adr_i == ufc_pkg::RegDivisor && wb_sel_i[1]) div_q <= wb_dat_i[15:0];
      if (wb_adr_i == ufc_pkg::RegWater)   water_q   <= wb_dat_i[5:0];
    end
  end

  // oversample tick divider; divisor 0 behaves as 1
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt_q <= '0;
      tick     <= 1'b0;
    end else if (divCnt_q + 16'd1 >= div_q) begin
      divCnt_q <= '0;
      tick     <= 1'b1;
    end else begin
      divCnt_q <= divCnt_q + 16'd1;
      tick     <= 1'b0;
    end
  end

  // two-stage synchronisers on the pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxSync_q  <= 2'b11;
      ctsSync_q <= 2'b11;
    end else begin
      rxSync_q  <= {rxSync_q[0], rxPin};
      ctsSync_q <= {ctsSync_q[0], ctsPin_n};
    end
  end

  // tx fifo storage
  always_ff @(posedge clk_sys) begin
    if (wrData) txMem[txWr_q[5:0]] <= wb_dat_i[7:0];
  end

  // tx fifo pointers; reset empties it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txWr_q <= '0;
      txRd_q <= '0;
    end else begin
      if (wrData) txWr_q <= txWr_q + 7'd1;
      if (txPop)  txRd_q <= txRd_q + 7'd1;
    end
  end

  // transmitter: frame loaded from fifo, cts checked only between frames
  assign txPop = (txSt_q == ufc_pkg::TxIdle) && !txEmpty && ctrl_q[ufc_pkg::CrEnable]
               && ctsOk && tick;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txSt_q   <= ufc_pkg::TxIdle;
      txShf_q  <= '1;
      txBits_q <= '0;
      txTick_q <= '0;
      txPin    <= 1'b1;
    end else begin
      txPin <= lineCtl_q[ufc_pkg::LcBreak] ? 1'b0 : txShf_q[0];
      unique case (txSt_q)
        ufc_pkg::TxIdle: begin
          txShf_q <= '1;
          if (txPop) begin
            logic [7:0] d;
            logic       p;
            d = txMem[txRd_q[5:0]];
            d = d & (8'hFF >> (4'd8 - dataLen));
            p = lineCtl_q[ufc_pkg::LcStick] ? !lineCtl_q[ufc_pkg::LcParEv]
                : (^d) ^ !lineCtl_q[ufc_pkg::LcParEv];
            // shift in order: start, data, optional parity, stop bits
            txShf_q  <= ({3'b111, p, d} << 1) | ({12'hFFF} << (dataLen + 4'd1));
            if (lineCtl_q[ufc_pkg::LcParEn])
              txShf_q <= (({3'b111, p, d} << 1) & ~(12'hFFF << (dataLen + 4'd2)))
                       | (12'hFFF << (dataLen + 4'd2)) | ({11'h0, 1'b0})
                       | ({11'h0, p} << (dataLen + 4'd1));
            txBits_q <= frameBits - 4'd1 + {3'b000, lineCtl_q[ufc_pkg::LcStop2]};
            txTick_q <= '0;
            txSt_q   <= ufc_pkg::TxShift;
          end
        end
        ufc_pkg::TxShift: begin
          if (tick) begin
            if (txTick_q == ovsLast) begin
              txTick_q <= '0;
              txShf_q  <= {1'b1, txShf_q[11:1]};
              if (txBits_q == 4'd0) txSt_q <= ufc_pkg::TxIdle;
              else txBits_q <= txBits_q - 4'd1;
            end else begin
              txTick_q <= txTick_q + 5'd1;
            end
          end
        end
        default: txSt_q <= ufc_pkg::TxIdle;
      endcase
    end
  end

  // receiver: start check, per-bit vote around the midpoint, break watch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxSt_q     <= ufc_pkg::RxIdle;
      rxTick_q   <= '0;
      rxBit_q    <= '0;
      rxShf_q    <= '0;
      rxParAcc_q <= 1'b0;
      parErr_q   <= 1'b0;
      vote_q     <= 3'b111;
      rxPush     <= 1'b0;
      rxEnt      <= '0;
      lowBits_q  <= '0;
    end else begin
      rxPush <= 1'b0;
      if (tick) vote_q <= {vote_q[1:0], rxIn};
      unique case (rxSt_q)
        ufc_pkg::RxIdle: begin
          rxTick_q  <= '0;
          lowBits_q <= '0;
          if (tick && !rxIn) rxSt_q <= ufc_pkg::RxStart;
        end
        ufc_pkg::RxStart: if (tick) begin
          if (rxTick_q == ovsMid) begin
            rxTick_q <= '0;
            rxBit_q  <= '0;
            rxParAcc_q <= lineCtl_q[ufc_pkg::LcParEv] ? 1'b0 : 1'b1;
            rxSt_q   <= rxIn ? ufc_pkg::RxIdle : ufc_pkg::RxBits;
          end else rxTick_q <= rxTick_q + 5'd1;
        end
        ufc_pkg::RxBits: if (tick) begin
          if (!rxIn) lowBits_q <= lowBits_q + 9'd1;
          if (rxTick_q == ovsLast) begin
            rxTick_q <= '0;
            rxBit_q  <= rxBit_q + 4'd1;
            if (rxBit_q < dataLen) begin
              rxShf_q    <= {majority, rxShf_q[7:1]};
              rxParAcc_q <= rxParAcc_q ^ majority;
            end else if (rxBit_q == dataLen && lineCtl_q[ufc_pkg::LcParEn]) begin
              parErr_q <= lineCtl_q[ufc_pkg::LcStick]
                        ? (majority != !lineCtl_q[ufc_pkg::LcParEv])
                        : (rxParAcc_q ^ majority);
            end else begin
              // stop bit: low means framing error, all-low frame means break
              rxEnt.data    <= rxShf_q >> (4'd8 - dataLen);
              rxEnt.framing <= !majority;
              rxEnt.parity  <= lineCtl_q[ufc_pkg::LcParEn] && parErr_q;
              // count this tick too, its own increment is not yet visible
              rxEnt.brk     <= !majority && (lowBits_q + 9'd1 >= {frameBits - 4'd1, 4'h0}
                               >> ctrl_q[ufc_pkg::CrOvs8]);
              rxEnt.overrun <= 1'b0;
              rxPush        <= 1'b1;
              parErr_q      <= 1'b0;
              rxSt_q <= majority ? ufc_pkg::RxIdle : ufc_pkg::RxBrk;
            end
          end else rxTick_q <= rxTick_q + 5'd1;
        end
        ufc_pkg::RxBrk: if (tick && rxIn) rxSt_q <= ufc_pkg::RxIdle;  // wait for line idle
        default: rxSt_q <= ufc_pkg::RxIdle;
      endcase
    end
  end

  // rx fifo with overrun carry to the next stored character
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxWr_q    <= '0;
      rxRd_q    <= '0;
      overrun_q <= 1'b0;
    end else begin
      if (rdData) rxRd_q <= rxRd_q + 7'd1;
      if (rxPush) begin
        if (rxFull && !rdData) begin
          overrun_q <= 1'b1;
        end else begin
          rxMem[rxWr_q[5:0]] <= '{overrun: overrun_q, brk: rxEnt.brk,
                                  parity: rxEnt.parity, framing: rxEnt.framing,
                                  data: rxEnt.data};
          rxWr_q    <= rxWr_q + 7'd1;
          overrun_q <= 1'b0;
        end
      end
    end
  end

  // rts: deasserted (high) once fill reaches watermark
  always_ff @(posedge clk_sys) begin
    if (rst) rtsPin_n <= 1'b1;
    else rtsPin_n <= ctrl_q[ufc_pkg::CrRtsEn] ? (rxCnt >= {1'b0, water_q})
                                              : !ctrl_q[ufc_pkg::CrEnable];
  end
endmodule : ufc_core

// ==== hw/ufc_pkg.sv ====
// Purpose: shared constants and types for the serial transmitter/receiver core
// Assumes: classic wishbone, 32-bit data, byte addresses on word boundaries
// Notes:   offsets and layouts are used by the core and by the bench
package ufc_pkg;
  localparam int unsigned FifoDepth   = 64;
  localparam int unsigned PtrW        = 6;
  localparam logic [7:0]  RegData     = 8'h00; // tx write / rx read
  localparam logic [7:0]  RegFlag     = 8'h04; // uart_flag_register
  localparam logic [7:0]  RegLineCtl  = 8'h08; // tx_line_control
  localparam logic [7:0]  RegCtrl     = 8'h0C;
  localparam logic [7:0]  RegDivisor  = 8'h10;
  localparam logic [7:0]  RegWater    = 8'h14;
  // line control bit positions
  localparam int unsigned LcBreak  = 0;
  localparam int unsigned LcParEn  = 1;
  localparam int unsigned LcParEv  = 2;
  localparam int unsigned LcStop2  = 3;
  localparam int unsigned LcFifoEn = 4;
  localparam int unsigned LcLenLo  = 5;  // 2-bit length: 0..3 means 5..8 bits
  localparam int unsigned LcStick  = 7;
  // control bit positions
  localparam int unsigned CrEnable = 0;
  localparam int unsigned CrOvs8   = 1;  // oversample_factor_sel
  localparam int unsigned CrRtsEn  = 2;  // request_to_send_enable
  localparam int unsigned CrCtsEn  = 3;  // clear_to_send_enable
  // flag register bit positions
  localparam int unsigned FrCts   = 0;
  localparam int unsigned FrBusy  = 3;
  localparam int unsigned FrRxEmp = 4;
  localparam int unsigned FrTxFul = 5;
  localparam int unsigned FrRxFul = 6;
  localparam int unsigned FrTxEmp = 7;
  // rx entry field positions
  localparam int unsigned RxFrame = 8;
  localparam int unsigned RxPar   = 9;
  localparam int unsigned RxBreak = 10;
  localparam int unsigned RxOver  = 11;
  localparam logic [7:0]  LineCtlReset = 8'h60;   // 8 bits, no parity, fifo off
  localparam logic [3:0]  CtrlReset    = 4'h0;
  localparam logic [15:0] DivReset     = 16'h0001;
  localparam logic [5:0]  WaterReset   = 6'h20;
  localparam logic [4:0]  StartCheck   = 5'd7;    // 8th tick after the edge
  localparam logic [31:0] BusUnmapped  = 32'h0000_0000;

  typedef enum logic [1:0] {TxIdle, TxShift} ufc_tx_e;
  typedef enum logic [1:0] {RxIdle, RxStart, RxBits, RxBrk} ufc_rx_e;

  typedef struct packed {
    logic       overrun;
    logic       brk;
    logic       parity;
    logic       framing;
    logic [7:0] data;
  } ufc_rxent_s;
endpackage : ufc_pkg

// ==== tb/ufc_core_monitor.sv ====
// Purpose: port-level checker for the serial core
// Assumes: divisor of one or more, so one bit lasts at least 8 clocks
// Notes:   bound to every ufc_core instance
`timescale 1ns/10ps
module ufc_core_monitor (
  input wire logic        clk_sys,  // system clock
  input wire logic        rst,      // sync reset
  input wire logic        wb_cyc_i, // cycle
  input wire logic        wb_stb_i, // strobe
  input wire logic        wb_we_i,  // write
  input wire logic [7:0]  wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic        wb_ack_o, // acknowledge
  input wire logic        txPin,    // serial out
  input wire logic        rtsPin_n  // request to send
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic flagRd;
  // the master still holds the request while ack is up
  assign flagRd = wb_ack_o && !wb_we_i && wb_adr_i == ufc_pkg::RegFlag;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed up");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> txPin && rtsPin_n)
    else $error("lines not idle after reset");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ufc_pkg::RegWater
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  rx_flags_a: assert property (flagRd |-> !(wb_dat_o[ufc_pkg::FrRxEmp] &&
    wb_dat_o[ufc_pkg::FrRxFul])) else $error("rx full and empty");
  tx_flags_a: assert property (flagRd |-> !(wb_dat_o[ufc_pkg::FrTxEmp] &&
    wb_dat_o[ufc_pkg::FrTxFul])) else $error("tx full and empty");
  busy_pending_a: assert property (flagRd && !wb_dat_o[ufc_pkg::FrTxEmp]
    |-> wb_dat_o[ufc_pkg::FrBusy]) else $error("busy low with tx data");
  start_width_a: assert property ($fell(txPin) |-> (!txPin) [*8])
    else $error("start bit too short");
  data_hold_a: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
    else $error("read data moved");
  cover property (flagRd);
  cover property ($fell(txPin));
  cover property (wb_ack_o && wb_we_i && wb_adr_i == ufc_pkg::RegData);
endmodule : ufc_core_monitor
bind ufc_core ufc_core_monitor i_ufc_core_monitor (.clk_sys(clk_sys), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txPin(txPin), .rtsPin_n(rtsPin_n));

// ==== tb/ufc_core_test.sv ====
// Purpose: self-checking bench for the serial core
// Assumes: divisor left at one, cts always asserted
// Notes:   byte lanes are tied on, every register uses lane0
`timescale 1ns/10ps
module ufc_core_test;
  logic        clk_sys = 1'b0;
  logic        rst, cyc, stb, we, ack, rxLine, txLine, ctsLine_n, rtsLine_n;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdOut, rdat;
  logic [8:0]  got;
  int          numErrors, totalChecks;
  // receive cases: line control, frame bits, bit count, expected entry
  // last case is an all-low frame: break plus framing
  logic [7:0]  lcT [8] = '{8'h60, 8'h60, 8'h66, 8'h66, 8'h62, 8'hE6, 8'h00, 8'h60};
  logic [11:0] frT [8] = '{12'h13C, 12'h055, 12'h201, 12'h301, 12'h201, 12'h355, 12'h035,
                           12'h000};
  logic [11:0] exT [8] = '{12'h03C, 12'h155, 12'h201, 12'h001, 12'h001, 12'h255, 12'h015,
                           12'h500};
  int          nT  [8] = '{9, 9, 10, 10, 10, 10, 6, 9};
  always #2.5 clk_sys = ~clk_sys;
  ufc_core i_ufc_core (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdOut),
    .wb_ack_o(ack), .rxPin(rxLine), .ctsPin_n(ctsLine_n), .txPin(txLine),
    .rtsPin_n(rtsLine_n));
  ufc_serial_peer i_ufc_serial_peer (.clk_sys(clk_sys), .lineOut(rxLine), .lineIn(txLine),
    .ctsOut_n(ctsLine_n));
  task automatic test_done();
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", what, e, s);
      numErrors++;
    end
  endtask : check
  // one classic cycle; read data is taken at the ack edge
  task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 64);
    rdat = rdOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 64) begin
      numErrors++;
      test_done();
    end
  endtask : wbXfer
  // expected tx capture: masked data with the stop bit above it
  function automatic logic [31:0] txExp(input logic [7:0] d, input int n);
    return (32'(d) & ((32'h1 << n) - 32'h1)) | (32'h1 << n);
  endfunction : txExp
  initial begin
    {rst, cyc, stb, we, adr, wdat, sel} = {1'b1, 3'h0, 8'h00, 32'h0, 4'hF};
    numErrors = 0;
    totalChecks = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("txIdle", 32'(txLine), 32'h1);
    check("rtsIdle", 32'(rtsLine_n), 32'h1);
    wbXfer(1'b0, ufc_pkg::RegFlag, 32'h0);
    check("flagReset", rdat & 32'hF8, 32'h90);
    wbXfer(1'b0, 8'h1C, 32'h0);
    check("unmapped", rdat, 32'h0);
    wbXfer(1'b1, ufc_pkg::RegCtrl, 32'h1);
    // back-to-back transmit at every length, busy while shifting
    for (int len = 5; len <= 8; len++) begin
      wbXfer(1'b1, ufc_pkg::RegLineCtl, (32'(len - 5) << 5) | 32'h10);
      wbXfer(1'b1, ufc_pkg::RegData, 32'(8'hC3 ^ 8'(len)));
      fork
        begin
          i_ufc_serial_peer.recvBits(len, got);
          check("txFirst", 32'(got), txExp(8'hC3 ^ 8'(len), len));
          i_ufc_serial_peer.recvBits(len, got);
          check("txSecond", 32'(got), txExp(8'h3C ^ 8'(len), len));
        end
        begin
          wbXfer(1'b1, ufc_pkg::RegData, 32'(8'h3C ^ 8'(len)));
          wbXfer(1'b0, ufc_pkg::RegFlag, 32'h0);
          check("busySet", 32'(rdat[ufc_pkg::FrBusy]), 32'h1);
        end
      join
      repeat (24) @(posedge clk_sys); // rest of the stop bit
      wbXfer(1'b0, ufc_pkg::RegFlag, 32'h0);
      check("busyClear", 32'(rdat[ufc_pkg::FrBusy]), 32'h0);
    end
    // receive: good, framing, parity kinds, short character
    for (int k = 0; k < 8; k++) begin
      wbXfer(1'b1, ufc_pkg::RegLineCtl, 32'(lcT[k]));
      i_ufc_serial_peer.sendBits(frT[k], nT[k]);
      wbXfer(1'b0, ufc_pkg::RegData, 32'h0);
      check("rxEntry", 32'(rdat[11:0]), 32'(exT[k]));
    end
    // rts flow control on from here, watermark left at its reset level of 32
    wbXfer(1'b1, ufc_pkg::RegCtrl, 32'h5);
    // overflow with the fifo off, then on
    for (int m = 0; m < 2; m++) begin
      int depth;
      depth = (m == 0) ? 1 : ufc_pkg::FifoDepth;
      wbXfer(1'b1, ufc_pkg::RegLineCtl, (m == 0) ? 32'h60 : 32'h70);
      for (int i = 0; i <= depth; i++) i_ufc_serial_peer.sendBits(12'h100 | 12'(i), 9);
      wbXfer(1'b0, ufc_pkg::RegFlag, 32'h0);
      check("rxFull", 32'(rdat[ufc_pkg::FrRxFul]), 32'h1);
      check("rtsFull", 32'(rtsLine_n), (m == 1) ? 32'h1 : 32'h0);
      for (int i = 0; i < depth; i++) begin
        wbXfer(1'b0, ufc_pkg::RegData, 32'h0);
        check("rxData", 32'(rdat[11:0]), 32'(i));
      end
      @(posedge clk_sys);
      check("rtsDrain", 32'(rtsLine_n), 32'h0);
      i_ufc_serial_peer.sendBits(12'h1EE, 9);
      wbXfer(1'b0, ufc_pkg::RegData, 32'h0);
      check("rxOverrun", 32'(rdat[11:0]), 32'h8EE);
    end
    i_ufc_serial_peer.glitch(4);
    wbXfer(1'b0, ufc_pkg::RegFlag, 32'h0);
    check("falseStart", 32'(rdat[ufc_pkg::FrRxEmp]), 32'h1);
    test_done();
  end
endmodule : ufc_core_test

// ==== tb/ufc_serial_peer.sv ====
// Purpose: remote serial device facing the core
// Assumes: divisor one, 16 clocks per bit
// Notes:   line idles high between frames
`timescale 1ns/10ps
module ufc_serial_peer #(
  parameter int BitClk = 16 // clocks per bit
) (
  input  wire logic clk_sys,  // timing clock
  output logic      lineOut,  // into the core
  input  wire logic lineIn,   // from the core
  output logic      ctsOut_n  // clear to send
);
  // always ready to take data
  initial begin
    lineOut = 1'b1;
    ctsOut_n = 1'b0;
  end
  // start bit, then n bits of v lsb first, then idle
  task automatic sendBits(input logic [11:0] v, input int n);
    logic [12:0] f;
    f = {v, 1'b0};
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys);
      lineOut <= f[i];
      repeat (BitClk - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    lineOut <= 1'b1;
    repeat (2 * BitClk) @(posedge clk_sys);
  endtask : sendBits
  // short low pulse that must not count as a start
  task automatic glitch(input int n);
    @(posedge clk_sys);
    lineOut <= 1'b0;
    repeat (n) @(posedge clk_sys);
    lineOut <= 1'b1;
    repeat (12 * BitClk) @(posedge clk_sys);
  endtask : glitch
  // n data bits and the stop bit, sampled near mid-bit; unknown on timeout
  task automatic recvBits(input int n, output logic [8:0] v);
    int t;
    v = 'x;
    t = 0;
    while (lineIn !== 1'b0 && t < 50000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t == 50000) return;
    v = '0;
    repeat (BitClk / 2) @(posedge clk_sys);
    for (int i = 0; i <= n; i++) begin
      repeat (BitClk) @(posedge clk_sys);
      v[i] = lineIn;
    end
  endtask : recvBits
endmodule : ufc_serial_peer
